// >>> hw/dachcb_bank.sv
// register bank for DAC dynamic channel, rate converter and headset timing
`timescale 1ns/100ps
`default_nettype none
module dachcb_bank #(
  parameter logic [7:0]  BANK_PAGE = dachcb_pkg::BANK_PAGE_DEFAULT,
  parameter logic [31:0] POLL_0_CYC  = 32'(dachcb_pkg::POLL_0_CYC),
  parameter logic [31:0] POLL_1_CYC  = 32'(dachcb_pkg::POLL_1_CYC),
  parameter logic [31:0] POLL_2_CYC  = 32'(dachcb_pkg::POLL_2_CYC),
  parameter logic [31:0] POLL_3_CYC  = 32'(dachcb_pkg::POLL_3_CYC),
  parameter logic [31:0] PROBE_0_CYC = 32'(dachcb_pkg::PROBE_0_CYC),
  parameter logic [31:0] PROBE_1_CYC = 32'(dachcb_pkg::PROBE_1_CYC),
  parameter logic [31:0] TICK_0_CYC  = 32'(dachcb_pkg::TICK_0_CYC),
  parameter logic [31:0] TICK_1_CYC  = 32'(dachcb_pkg::TICK_1_CYC),
  parameter logic [31:0] TICK_2_CYC  = 32'(dachcb_pkg::TICK_2_CYC)
) (
  input  wire logic                       sys_clk_in,
  input  wire logic                       rst_n_in,
  input  wire dachcb_pkg::dachcb_req_type req_in,
  input  wire logic [3:0]                 dac_auto_peak_channel_choice_in,
  output logic [7:0]                      rdata_out,
  output logic                            rvalid_out,
  output logic [7:0]                      page_out,
  output dachcb_pkg::dachcb_cfg_type      cfg_out
);
  import dachcb_pkg::*;

  logic [7:0]     page_ff;
  logic [7:0]     nxt_page;
  logic [7:0]     dyn_ch_ff;
  logic [7:0]     nxt_dyn_ch;
  logic [7:0]     conv_en_ff;
  logic [7:0]     nxt_conv_en;
  logic [7:0]     ratio_ff;
  logic [7:0]     nxt_ratio;
  logic [7:0]     hs_tim_ff;
  logic [7:0]     nxt_hs_tim;
  logic [7:0]     rdata_ff;
  logic [7:0]     nxt_rdata;
  logic           rvalid_ff;
  logic           nxt_rvalid;
  dachcb_cfg_type cfg_ff;
  dachcb_cfg_type nxt_cfg;
  logic           bank_sel;

  // reserved codes fall back to automatic inference rather than an undefined ratio
  function automatic logic ratio_is_auto(input logic [2:0] code);
    ratio_is_auto = (code == RATIO_AUTO_CODE) || (code == 3'h5) || (code == 3'h7);
  endfunction

  function automatic logic [2:0] ratio_value(input logic [2:0] code);
    ratio_value = ratio_is_auto(code) ? 3'h0 : code;
  endfunction

  // the page register answers on every page so software can always leave one
  assign bank_sel = (page_ff == BANK_PAGE);

  always_comb begin
    nxt_page   = page_ff;
    nxt_dyn_ch = dyn_ch_ff;
    nxt_conv_en = conv_en_ff;
    nxt_ratio  = ratio_ff;
    nxt_hs_tim = hs_tim_ff;
    if (req_in.wr) begin
      if (req_in.addr == PAGE_SELECT_ADDR) begin
        nxt_page = req_in.wdata;
      end else if (bank_sel) begin
        // reserved positions never store, so they read back zero
        case (req_in.addr)
          DAC_DYN_CH_CFG_ADDR:  nxt_dyn_ch  = req_in.wdata & DAC_DYN_CH_CFG_MASK;
          RATE_CONV_EN_ADDR:    nxt_conv_en = req_in.wdata & RATE_CONV_EN_MASK;
          RATE_CONV_RATIO_ADDR: nxt_ratio   = req_in.wdata & RATE_CONV_RATIO_MASK;
          HEADSET_TIMING_ADDR:  nxt_hs_tim  = req_in.wdata & HEADSET_TIMING_MASK;
          default: begin
          end
        endcase
      end
    end
  end

  always_comb begin
    nxt_rvalid = req_in.rd;
    nxt_rdata  = 8'h00;
    if (req_in.rd) begin
      if (req_in.addr == PAGE_SELECT_ADDR) begin
        nxt_rdata = page_ff;
      end else if (bank_sel) begin
        case (req_in.addr)
          DAC_DYN_CH_CFG_ADDR:  nxt_rdata = dyn_ch_ff;
          RATE_CONV_EN_ADDR:    nxt_rdata = conv_en_ff;
          RATE_CONV_RATIO_ADDR: nxt_rdata = ratio_ff;
          HEADSET_TIMING_ADDR:  nxt_rdata = hs_tim_ff;
          default:              nxt_rdata = 8'h00;
        endcase
      end
    end
  end

  // settings are decoded from the stored registers, one cycle behind a write
  always_comb begin
    nxt_cfg = cfg_ff;
    nxt_cfg.peak_channel_mask = dyn_ch_ff[OVERRIDE_PEAK_BIT] ?
                                dyn_ch_ff[CUSTOM_MASK_LSB +: 4] :
                                dac_auto_peak_channel_choice_in;
    nxt_cfg.rate_converter_on  = conv_en_ff[RATE_CONV_ON_BIT];
    nxt_cfg.rate_detect_active = ~conv_en_ff[DETECT_INHIBIT_BIT];
    if (!ratio_ff[MAIN_MANUAL_BIT]) begin
      nxt_cfg.main_rate_src = DACHCB_MAIN_AUTO;
    end else if (!ratio_ff[MAIN_SOURCE_BIT]) begin
      nxt_cfg.main_rate_src = DACHCB_MAIN_PRIMARY;
    end else begin
      nxt_cfg.main_rate_src = DACHCB_MAIN_SECONDARY;
    end
    nxt_cfg.ratio_num_auto = ratio_is_auto(ratio_ff[RATIO_NUM_LSB +: 3]);
    nxt_cfg.ratio_num      = ratio_value(ratio_ff[RATIO_NUM_LSB +: 3]);
    nxt_cfg.ratio_den_auto = ratio_is_auto(ratio_ff[RATIO_DEN_LSB +: 3]);
    nxt_cfg.ratio_den      = ratio_value(ratio_ff[RATIO_DEN_LSB +: 3]);
    case (hs_tim_ff[POLL_RATE_LSB +: 2])
      2'h0:    nxt_cfg.poll_period_cyc = POLL_0_CYC;
      2'h1:    nxt_cfg.poll_period_cyc = POLL_1_CYC;
      2'h2:    nxt_cfg.poll_period_cyc = POLL_2_CYC;
      default: nxt_cfg.poll_period_cyc = POLL_3_CYC;
    endcase
    nxt_cfg.probe_high_cyc = hs_tim_ff[PROBE_HIGH_BIT] ? PROBE_1_CYC : PROBE_0_CYC;
    // reserved tick code keeps the longest period and raises a flag
    nxt_cfg.tick_code_bad = (hs_tim_ff[TICK_PERIOD_LSB +: 2] == TICK_RESERVED_CODE);
    case (hs_tim_ff[TICK_PERIOD_LSB +: 2])
      2'h0:    nxt_cfg.tick_period_cyc = TICK_0_CYC;
      2'h1:    nxt_cfg.tick_period_cyc = TICK_1_CYC;
      default: nxt_cfg.tick_period_cyc = TICK_2_CYC;
    endcase
  end

  always_ff @(posedge sys_clk_in) begin
    if (!rst_n_in) begin
      page_ff    <= REG_RESET_VALUE;
      dyn_ch_ff  <= REG_RESET_VALUE;
      conv_en_ff <= REG_RESET_VALUE;
      ratio_ff   <= REG_RESET_VALUE;
      hs_tim_ff  <= REG_RESET_VALUE;
      rdata_ff   <= 8'h00;
      rvalid_ff  <= 1'b0;
      cfg_ff     <= '0;
    end else begin
      page_ff    <= nxt_page;
      dyn_ch_ff  <= nxt_dyn_ch;
      conv_en_ff <= nxt_conv_en;
      ratio_ff   <= nxt_ratio;
      hs_tim_ff  <= nxt_hs_tim;
      rdata_ff   <= nxt_rdata;
      rvalid_ff  <= nxt_rvalid;
      cfg_ff     <= nxt_cfg;
    end
  end

  assign rdata_out  = rdata_ff;
  assign rvalid_out = rvalid_ff;
  assign page_out   = page_ff;
  assign cfg_out    = cfg_ff;

endmodule
`default_nettype wire

// >>> include/dachcb_pkg.sv
// constants and carrier types of the DAC rate and headset configuration bank
// How it works
// - with the override bit clear the dynamic DAC mode uses the automatic peak-channel choice, with it set the custom mask.
// - custom mask bit 3 enables channel four, bit 2 channel three, bit 1 channel two, bit 0 channel one.
// - reserved bits read as zero and software writes only zero to them.
// - the rate converter is off while its enable bit is 0 and on while it is 1.
// - automatic rate detection runs while the inhibit bit is 0 and stops while it is 1.
// - with the manual bit at 0 the main rate is inferred, at 1 it comes from the source bit.
// - under manual selection source 0 picks the primary serial port frame rate, source 1 the secondary.
// - ratio numerator code 0 is automatic, codes 1 to 4 give 1 to 4, code 6 gives 6, codes 5 and 7 are reserved.
// - ratio denominator code 0 is automatic, codes 1 to 4 give 1 to 4, code 6 gives 6, codes 5 and 7 are reserved.
// - the headset poll rate codes 0 to 3 give 0.5 Hz, 1 Hz, 7.5 Hz and 15 Hz.
// - the headset probe high time is 4 ms with its bit at 0 and 32 ms with it at 1.
// - the phone detect tick period codes 0 to 2 give 1 ms, 2 ms and 4 ms, code 3 is reserved.
// - every register of the bank holds 0x00 after reset.
// - the map is paged through a page register at address 0 that software sets before reaching the bank.
package dachcb_pkg;

  // register addresses within the selected page
  localparam logic [7:0] PAGE_SELECT_ADDR     = 8'h00;
  localparam logic [7:0] DAC_DYN_CH_CFG_ADDR  = 8'h0F;
  localparam logic [7:0] RATE_CONV_EN_ADDR    = 8'h17;
  localparam logic [7:0] RATE_CONV_RATIO_ADDR = 8'h18;
  localparam logic [7:0] HEADSET_TIMING_ADDR  = 8'h19;

  localparam logic [7:0] REG_RESET_VALUE = 8'h00;
  localparam logic [7:0] BANK_PAGE_DEFAULT = 8'h00;

  // writable-bit masks, reserved positions zero
  localparam logic [7:0] DAC_DYN_CH_CFG_MASK  = 8'hF8;
  localparam logic [7:0] RATE_CONV_EN_MASK    = 8'hC0;
  localparam logic [7:0] RATE_CONV_RATIO_MASK = 8'hFF;
  localparam logic [7:0] HEADSET_TIMING_MASK  = 8'hE6;

  // field positions
  localparam int OVERRIDE_PEAK_BIT   = 7;
  localparam int CUSTOM_MASK_LSB     = 3;
  localparam int RATE_CONV_ON_BIT    = 7;
  localparam int DETECT_INHIBIT_BIT  = 6;
  localparam int MAIN_MANUAL_BIT     = 7;
  localparam int MAIN_SOURCE_BIT     = 6;
  localparam int RATIO_NUM_LSB       = 3;
  localparam int RATIO_DEN_LSB       = 0;
  localparam int POLL_RATE_LSB       = 6;
  localparam int PROBE_HIGH_BIT      = 5;
  localparam int TICK_PERIOD_LSB     = 1;

  localparam logic [2:0] RATIO_AUTO_CODE = 3'h0;
  localparam logic [1:0] TICK_RESERVED_CODE = 2'h3;

  // timing: figures in their own unit, counts derived from the clock rate
  localparam longint CLK_HZ = 250000000;
  localparam longint POLL_0_5_HZ_X10 = 5;
  localparam longint POLL_1_HZ_X10   = 10;
  localparam longint POLL_7_5_HZ_X10 = 75;
  localparam longint POLL_15_HZ_X10  = 150;
  localparam longint PROBE_SHORT_MS = 4;
  localparam longint PROBE_LONG_MS  = 32;
  localparam longint TICK_1_MS = 1;
  localparam longint TICK_2_MS = 2;
  localparam longint TICK_4_MS = 4;

  localparam longint POLL_0_CYC   = (CLK_HZ * 10) / POLL_0_5_HZ_X10;
  localparam longint POLL_1_CYC   = (CLK_HZ * 10) / POLL_1_HZ_X10;
  localparam longint POLL_2_CYC   = (CLK_HZ * 10) / POLL_7_5_HZ_X10;
  localparam longint POLL_3_CYC   = (CLK_HZ * 10) / POLL_15_HZ_X10;
  localparam longint PROBE_0_CYC  = (CLK_HZ * PROBE_SHORT_MS) / 1000;
  localparam longint PROBE_1_CYC  = (CLK_HZ * PROBE_LONG_MS) / 1000;
  localparam longint TICK_0_CYC   = (CLK_HZ * TICK_1_MS) / 1000;
  localparam longint TICK_1_CYC   = (CLK_HZ * TICK_2_MS) / 1000;
  localparam longint TICK_2_CYC   = (CLK_HZ * TICK_4_MS) / 1000;

  typedef enum logic [1:0] {
    DACHCB_MAIN_AUTO,
    DACHCB_MAIN_PRIMARY,
    DACHCB_MAIN_SECONDARY
  } dachcb_main_src_type;

  // register access request from the control port
  typedef struct packed {
    logic       wr;
    logic       rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } dachcb_req_type;

  // decoded settings handed to the datapath
  typedef struct packed {
    logic [3:0]          peak_channel_mask;
    logic                rate_converter_on;
    logic                rate_detect_active;
    dachcb_main_src_type main_rate_src;
    logic                ratio_num_auto;
    logic [2:0]          ratio_num;
    logic                ratio_den_auto;
    logic [2:0]          ratio_den;
    logic [31:0]         poll_period_cyc;
    logic [31:0]         probe_high_cyc;
    logic [31:0]         tick_period_cyc;
    logic                tick_code_bad;
  } dachcb_cfg_type;

endpackage

// >>> verification/dachcb_bank_sva.sv
// port assertions for the rate and headset configuration bank
`timescale 1ns/100ps
`default_nettype none
module dachcb_bank_sva #(
  parameter logic [31:0] PROBE_0_CYC = 32'(dachcb_pkg::PROBE_0_CYC),
  parameter logic [31:0] PROBE_1_CYC = 32'(dachcb_pkg::PROBE_1_CYC)
) (
  input wire logic                       sys_clk_in,
  input wire logic                       rst_n_in,
  input wire dachcb_pkg::dachcb_req_type req_in,
  input wire logic [3:0]                 dac_auto_peak_channel_choice_in,
  input wire logic [7:0]                 rdata_out,
  input wire logic                       rvalid_out,
  input wire logic [7:0]                 page_out,
  input wire dachcb_pkg::dachcb_cfg_type cfg_out
);
  import dachcb_pkg::*;
  default clocking cb @(posedge sys_clk_in); endclocking
  default disable iff (!rst_n_in);
  // bank register writes only land while the bank's page is selected
  logic wk;
  assign wk = req_in.wr && (page_out == BANK_PAGE_DEFAULT);
  property p_rv_on; req_in.rd |=> rvalid_out; endproperty
  a_rv_on: assert property (p_rv_on) else $error("read not answered");
  property p_rv_off; !req_in.rd |=> !rvalid_out && rdata_out == 8'h00; endproperty
  a_rv_off: assert property (p_rv_off) else $error("stray read data");
  property p_rsv; rvalid_out && $past(req_in.addr) == 8'h17 |-> rdata_out[5:0] == 6'h00; endproperty
  a_rsv: assert property (p_rsv) else $error("reserved bits not zero");
  property p_conv; wk && req_in.addr == 8'h17 |-> ##2 cfg_out.rate_converter_on == $past(req_in.wdata[7], 2); endproperty
  a_conv: assert property (p_conv) else $error("converter enable wrong");
  property p_det; wk && req_in.addr == 8'h17 |-> ##2 cfg_out.rate_detect_active == !$past(req_in.wdata[6], 2); endproperty
  a_det: assert property (p_det) else $error("rate detect wrong");
  property p_src; wk && req_in.addr == 8'h18 |-> ##2 2'(cfg_out.main_rate_src) ==
    ($past(req_in.wdata[7], 2) ? ($past(req_in.wdata[6], 2) ? 2'h2 : 2'h1) : 2'h0); endproperty
  a_src: assert property (p_src) else $error("main rate source wrong");
  property p_probe; wk && req_in.addr == 8'h19 |-> ##2
    cfg_out.probe_high_cyc == ($past(req_in.wdata[5], 2) ? PROBE_1_CYC : PROBE_0_CYC); endproperty
  a_probe: assert property (p_probe) else $error("probe time wrong");
  property p_tick_bad; wk && req_in.addr == 8'h19 |-> ##2 cfg_out.tick_code_bad == ($past(req_in.wdata[2:1], 2) == 2'h3); endproperty
  a_tick_bad: assert property (p_tick_bad) else $error("tick code flag wrong");
  property p_cust; wk && req_in.addr == 8'h0F && req_in.wdata[7] |-> ##2 cfg_out.peak_channel_mask == $past(req_in.wdata[6:3], 2); endproperty
  a_cust: assert property (p_cust) else $error("custom mask wrong");
  property p_auto; wk && req_in.addr == 8'h0F && !req_in.wdata[7] |-> ##2
    cfg_out.peak_channel_mask == $past(dac_auto_peak_channel_choice_in); endproperty
  a_auto: assert property (p_auto) else $error("auto mask wrong");
  property p_page; req_in.wr && req_in.addr == 8'h00 |=> page_out == $past(req_in.wdata); endproperty
  a_page: assert property (p_page) else $error("page not stored");
endmodule
bind dachcb_bank dachcb_bank_sva #(.PROBE_0_CYC(PROBE_0_CYC), .PROBE_1_CYC(PROBE_1_CYC)) dachcb_chk_u (
  .sys_clk_in(sys_clk_in), .rst_n_in(rst_n_in), .req_in(req_in),
  .dac_auto_peak_channel_choice_in(dac_auto_peak_channel_choice_in), .rdata_out(rdata_out),
  .rvalid_out(rvalid_out), .page_out(page_out), .cfg_out(cfg_out));
`default_nettype wire

// >>> verification/tb_top.sv
// self-checking bench for the rate and headset configuration bank
`timescale 1ns/100ps
`default_nettype none
module tb_top;
  import dachcb_pkg::*;
  // decoded counts at the default clock rate; nothing counts them down, so the run stays short
  localparam logic [31:0] PL[4] = '{32'(POLL_0_CYC), 32'(POLL_1_CYC), 32'(POLL_2_CYC), 32'(POLL_3_CYC)};
  localparam logic [31:0] TK[4] = '{32'(TICK_0_CYC), 32'(TICK_1_CYC), 32'(TICK_2_CYC), 32'(TICK_2_CYC)};
  localparam logic [7:0]  AD[4] = '{8'h0F, 8'h17, 8'h18, 8'h19};
  localparam logic [7:0]  MK[4] = '{8'hF8, 8'hC0, 8'hFF, 8'hE6};
  logic           sys_clk_in = 1'b0;
  logic           rst_n_in = 1'b0;
  dachcb_req_type req = '0;
  logic [3:0]     auto_ch = 4'hA;
  logic [7:0]     rdata;
  logic           rvalid;
  logic [7:0]     page;
  dachcb_cfg_type cfg;
  logic [7:0]     wv;
  int             failures = 0;
  int             cmp_count = 0;
  always #2 sys_clk_in = ~sys_clk_in;
  dachcb_bank dut_u (.sys_clk_in(sys_clk_in), .rst_n_in(rst_n_in), .req_in(req),
    .dac_auto_peak_channel_choice_in(auto_ch), .rdata_out(rdata), .rvalid_out(rvalid),
    .page_out(page), .cfg_out(cfg));
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    cmp_count++;
    if (g !== e) begin
      failures++;
      $display("CHECK FAILED %s expected %0h seen %0h", n, e, g);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge sys_clk_in);
    req <= '{1'b1, 1'b0, a, d};
    @(posedge sys_clk_in);
    req.wr <= 1'b0;
  endtask
  // waits until the decoded settings have caught up with the write
  task automatic wrc(input logic [7:0] a, input logic [7:0] d);
    wr(a, d);
    @(posedge sys_clk_in);
    #1;
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    @(posedge sys_clk_in);
    req <= '{1'b0, 1'b1, a, 8'h00};
    @(posedge sys_clk_in);
    req.rd <= 1'b0;
    #1;
    chk("rvalid", 32'h1, 32'(rvalid));
    chk("rdata", 32'(e), 32'(rdata));
  endtask
  function automatic logic [3:0] rt(input int c);
    return (c == 0 || c == 5 || c == 7) ? 4'h8 : 4'(c);
  endfunction
  task automatic results();
    $display("comparisons %0d mismatches %0d", cmp_count, failures);
    if (failures == 0 && cmp_count > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  initial begin
    repeat (6) @(posedge sys_clk_in);
    rst_n_in <= 1'b1;
    foreach (AD[i]) rd(AD[i], 8'h00);
    chk("detect", 32'h1, 32'(cfg.rate_detect_active));
    chk("poll", PL[0], cfg.poll_period_cyc);
    chk("mask", 32'(auto_ch), 32'(cfg.peak_channel_mask));
    $display("test reset done");
    foreach (AD[i]) begin
      wr(AD[i], 8'hFF);
      rd(AD[i], MK[i]);
    end
    chk("conv", 32'h1, 32'(cfg.rate_converter_on));
    chk("detect", 32'h0, 32'(cfg.rate_detect_active));
    chk("mask", 32'hF, 32'(cfg.peak_channel_mask));
    $display("test readback done");
    for (int i = 0; i < 8; i++) begin
      wv = {i[1:0], i[2:0], 3'(7 - i)};
      wrc(8'h18, wv);
      chk("src", i[1] ? (i[0] ? 32'h2 : 32'h1) : 32'h0, 32'(cfg.main_rate_src));
      chk("num", 32'(rt(i)), 32'({cfg.ratio_num_auto, cfg.ratio_num}));
      chk("den", 32'(rt(7 - i)), 32'({cfg.ratio_den_auto, cfg.ratio_den}));
      if (i < 4) begin
        wrc(8'h19, {i[1:0], i[0], 2'h0, i[1:0], 1'b0});
        chk("poll", PL[i], cfg.poll_period_cyc);
        chk("probe", i[0] ? 32'(PROBE_1_CYC) : 32'(PROBE_0_CYC), cfg.probe_high_cyc);
        chk("tick", TK[i], cfg.tick_period_cyc);
        chk("tick_bad", 32'(i == 3), 32'(cfg.tick_code_bad));
      end
    end
    $display("test decode done");
    wrc(8'h0F, 8'h28);
    chk("mask", 32'hA, 32'(cfg.peak_channel_mask));
    // automatic choice must be followed while the override is clear
    @(posedge sys_clk_in);
    auto_ch <= 4'h3;
    repeat (2) @(posedge sys_clk_in);
    #1;
    chk("mask", 32'h3, 32'(cfg.peak_channel_mask));
    wrc(8'h0F, 8'hA8);
    chk("mask", 32'h5, 32'(cfg.peak_channel_mask));
    wrc(8'h0F, 8'hC0);
    chk("mask", 32'h8, 32'(cfg.peak_channel_mask));
    // with the override set the automatic choice must be ignored
    @(posedge sys_clk_in);
    auto_ch <= 4'hC;
    repeat (2) @(posedge sys_clk_in);
    #1;
    chk("mask", 32'h8, 32'(cfg.peak_channel_mask));
    $display("test peak channel done");
    wr(8'h00, 8'h01);
    rd(8'h17, 8'h00);
    wr(8'h17, 8'h00);
    rd(8'h00, 8'h01);
    wr(8'h00, 8'h00);
    rd(8'h17, 8'hC0);
    rd(8'h10, 8'h00);
    $display("test paging done");
    wr(8'h00, 8'h02);
    @(posedge sys_clk_in);
    rst_n_in <= 1'b0;
    repeat (2) @(posedge sys_clk_in);
    rst_n_in <= 1'b1;
    @(posedge sys_clk_in);
    #1;
    chk("page", 32'h0, 32'(page));
    rd(8'h18, 8'h00);
    rd(8'h17, 8'h00);
    $display("test second reset done");
    results();
  end
endmodule
`default_nettype wire
